// ---- rtl/slsio_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module slsio_top
  import slsio_pkg::*;
#(
  parameter int BLINK_CYC = BLINK_HALF_CYC,
  parameter int PROG_DEPTH = N_PROG
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [N_IN-1:0] in_lines,
  input wire logic [PROG_W-1:0] prog_code_pins,
  input wire logic feed_fault,
  input wire logic unit_fault,
  input wire logic prog_done,
  output logic [N_OUT-1:0] out_lines,
  output logic soldering_enable,
  output logic irq
);
  localparam int PI_W = $clog2(PROG_DEPTH);
  localparam int BC_W = $clog2(BLINK_CYC + 1);

  if (BLINK_CYC < 1 || PROG_DEPTH < 2 || N_IN > (1 << SEL_W) || N_OUT > (1 << SEL_W)) begin : g_bad
    $error("slsio_top: unsupported parameter values");
  end

  // pick the level on a selected line; an out-of-range number reads as inactive
  function automatic logic pick(input logic [N_IN-1:0] lines, input logic [SEL_W-1:0] sel);
    pick = (int'(sel) < N_IN) ? lines[sel] : 1'b0;
  endfunction

  // true when any two in-range fields of a map select the same line
  function automatic logic has_dup(input logic [N_IFUNC*SEL_W-1:0] map, input int n, input int lim);
    has_dup = 1'b0;
    for (int a = 0; a < n; a++) begin
      for (int b = a + 1; b < n; b++) begin
        if (map[a*SEL_W +: SEL_W] == map[b*SEL_W +: SEL_W] && int'(map[a*SEL_W +: SEL_W]) < lim) begin
          has_dup = 1'b1;
        end
      end
    end
  endfunction

  // three-stage synchronisers for pins; s1 feeds only s2
  logic [N_IN-1:0] in_s1_r, in_s2_r, in_s3_r, in_f_r, in_f_nxt;
  logic [PROG_W-1:0] pc_s1_r, pc_s2_r, pc_s3_r, pc_f_r, pc_f_nxt;

  // a change counts once stages two and three agree
  always_comb begin
    in_f_nxt = (in_s2_r & ~(in_s2_r ^ in_s3_r)) | (in_f_r & (in_s2_r ^ in_s3_r));
    pc_f_nxt = (pc_s2_r & ~(pc_s2_r ^ pc_s3_r)) | (pc_f_r & (pc_s2_r ^ pc_s3_r));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_s1_r <= '0;
      in_s2_r <= '0;
      in_s3_r <= '0;
      in_f_r <= '0;
      pc_s1_r <= '0;
      pc_s2_r <= '0;
      pc_s3_r <= '0;
      pc_f_r <= '0;
    end else begin
      in_s1_r <= in_lines;
      in_s2_r <= in_s1_r;
      in_s3_r <= in_s2_r;
      in_f_r <= in_f_nxt;
      pc_s1_r <= prog_code_pins;
      pc_s2_r <= pc_s1_r;
      pc_s3_r <= pc_s2_r;
      pc_f_r <= pc_f_nxt;
    end
  end

  // register state
  logic mchk_r, mchk_nxt;
  logic [N_OFUNC*SEL_W-1:0] omap_r, omap_nxt;
  logic [N_IFUNC*SEL_W-1:0] imap_r, imap_nxt;
  logic [IRQ_W-1:0] istat_r, istat_nxt, ien_r, ien_nxt, ev;
  logic [PI_W-1:0] ptab_a_r, ptab_a_nxt;
  logic [31:0] prdata_nxt;
  slsio_state_t st_r, st_nxt;
  slsio_lamp_t lamp_r, lamp_nxt;
  slsio_fin_t fin;
  logic start_q_r, prog_q_r, map_err_r, map_err_nxt;
  logic scan_r, scan_nxt, chk_r, chk_nxt, pvalid_r, pvalid_nxt;
  logic [PI_W-1:0] sidx_r, sidx_nxt, cidx_r, cidx_nxt, pidx_r, pidx_nxt;
  logic [PROG_W-1:0] pcode_r, pcode_nxt, mem_rd;
  logic [BC_W-1:0] bcnt_r, bcnt_nxt;
  logic blink_r, blink_nxt, solder_nxt;
  // search events kept apart so the event vector has a single writer
  logic ev_found, ev_miss;
  logic [N_OUT-1:0] out_nxt;

  wire logic wr = psel & penable & pwrite;
  wire logic rd_setup = psel & ~penable & ~pwrite;
  wire logic ctrl_wr = wr && paddr == A_CTRL;
  wire logic h_start = ctrl_wr & pwdata[CTRL_START];
  wire logic h_pause = ctrl_wr & pwdata[CTRL_PAUSE];
  wire logic h_stop = ctrl_wr & pwdata[CTRL_STOP];
  wire logic h_resume = ctrl_wr & pwdata[CTRL_RESUME];
  wire logic h_eclr = ctrl_wr & pwdata[CTRL_ECLR];
  wire logic ptab_we = wr && paddr == A_PTAB_DATA;

  // input functions taken from their assigned lines
  always_comb begin
    fin.estop = pick(in_f_r, imap_r[0*SEL_W +: SEL_W]);
    fin.start = pick(in_f_r, imap_r[1*SEL_W +: SEL_W]);
    fin.prog = pick(in_f_r, imap_r[2*SEL_W +: SEL_W]);
    fin.area_estop = pick(in_f_r, imap_r[3*SEL_W +: SEL_W]);
    fin.area_pause = pick(in_f_r, imap_r[4*SEL_W +: SEL_W]);
    fin.area2 = pick(in_f_r, imap_r[5*SEL_W +: SEL_W]);
  end

  wire logic start_edge = fin.start & ~start_q_r;
  wire logic prog_edge = fin.prog & ~prog_q_r;
  // area2 only counts in the run state, which includes motion-check runs
  wire logic estop_req = fin.estop | fin.area_estop | (fin.area2 & st_r == ST_RUN);
  wire logic estop_hold = fin.estop | fin.area_estop;

  // program state machine
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if ((start_edge | h_start) & pvalid_r & ~scan_r) begin
          st_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (start_edge | h_stop | prog_done) begin
          st_nxt = ST_IDLE;
        end else if (fin.area_pause | h_pause) begin
          st_nxt = ST_PAUSE;
        end else if (feed_fault | unit_fault) begin
          st_nxt = ST_FPAUSE;
        end
      end
      ST_PAUSE, ST_FPAUSE: begin
        if (h_stop) begin
          st_nxt = ST_IDLE;
        end else if ((h_resume | start_edge) & ~fin.area_pause) begin
          st_nxt = ST_RUN;
        end
      end
      ST_ESTOP: begin
        // leaving needs software and a released stop source
        if (h_eclr & ~estop_hold) begin
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
    if (estop_req && st_r != ST_ESTOP) begin
      st_nxt = ST_ESTOP;
    end
  end

  // program-number search over the stored table
  always_comb begin
    scan_nxt = scan_r;
    sidx_nxt = sidx_r;
    chk_nxt = 1'b0;
    cidx_nxt = sidx_r;
    pcode_nxt = pcode_r;
    pidx_nxt = pidx_r;
    pvalid_nxt = pvalid_r;
    ev_found = 1'b0;
    ev_miss = 1'b0;
    if (scan_r) begin
      chk_nxt = 1'b1;
      if (int'(sidx_r) < PROG_DEPTH - 1) begin
        sidx_nxt = sidx_r + 1'b1;
      end else begin
        scan_nxt = 1'b0;
      end
    end
    if (chk_r) begin
      if (mem_rd == pcode_r) begin
        pidx_nxt = cidx_r;
        pvalid_nxt = 1'b1;
        ev_found = 1'b1;
        scan_nxt = 1'b0;
        chk_nxt = 1'b0;
      end else if (int'(cidx_r) == PROG_DEPTH - 1) begin
        ev_miss = 1'b1;
      end
    end
    // a new select restarts the search; loading is refused while running
    if (prog_edge && st_r == ST_IDLE) begin
      pcode_nxt = pc_f_r;
      scan_nxt = 1'b1;
      sidx_nxt = '0;
      chk_nxt = 1'b0;
      pvalid_nxt = 1'b0;
    end
  end

  // lamp decisions from the state; run includes motion-check runs
  always_comb begin
    bcnt_nxt = bcnt_r + 1'b1;
    blink_nxt = blink_r;
    if (int'(bcnt_r) >= BLINK_CYC - 1) begin
      bcnt_nxt = '0;
      blink_nxt = ~blink_r;
    end
    lamp_nxt.operating = st_r == ST_RUN || st_r == ST_PAUSE || st_r == ST_FPAUSE;
    lamp_nxt.idle = st_r != ST_RUN;
    lamp_nxt.fault = st_r == ST_FPAUSE || st_r == ST_ESTOP;
    lamp_nxt.activity = lamp_nxt.operating & blink_r;
    solder_nxt = st_nxt == ST_RUN && !mchk_r;
    map_err_nxt = has_dup({8'h00, omap_r}, N_OFUNC, N_OUT) | has_dup(imap_r, N_IFUNC, N_IN);
    out_nxt = '0;
    for (int f = 0; f < N_OFUNC; f++) begin
      for (int l = 0; l < N_OUT; l++) begin
        if (int'(omap_r[f*SEL_W +: SEL_W]) == l && lamp_r[f]) begin
          out_nxt[l] = 1'b1;
        end
      end
    end
  end

  // register file writes, sticky status and read capture
  always_comb begin
    mchk_nxt = mchk_r;
    omap_nxt = omap_r;
    imap_nxt = imap_r;
    ien_nxt = ien_r;
    ptab_a_nxt = ptab_a_r;
    ev[IRQ_ESTOP] = st_nxt == ST_ESTOP && st_r != ST_ESTOP;
    ev[IRQ_FAULT] = st_nxt == ST_FPAUSE && st_r != ST_FPAUSE;
    ev[IRQ_STOP] = st_nxt == ST_IDLE && st_r != ST_IDLE;
    ev[IRQ_MAPERR] = map_err_nxt & ~map_err_r;
    ev[IRQ_PFOUND] = ev_found;
    ev[IRQ_PMISS] = ev_miss;
    istat_nxt = istat_r;
    if (wr) begin
      case (paddr)
        A_CTRL: mchk_nxt = pwdata[CTRL_MCHK];
        A_OUTMAP: omap_nxt = pwdata[N_OFUNC*SEL_W-1:0];
        A_INMAP: imap_nxt = pwdata[N_IFUNC*SEL_W-1:0];
        A_INT_CLR: istat_nxt = istat_r & ~pwdata[IRQ_W-1:0];
        A_INT_EN: ien_nxt = pwdata[IRQ_W-1:0];
        A_PTAB_ADDR: ptab_a_nxt = pwdata[PI_W-1:0];
        default: ;
      endcase
    end
    // a new event wins over a clear in the same cycle
    istat_nxt = istat_nxt | ev;
    prdata_nxt = prdata;
    if (rd_setup) begin
      prdata_nxt = '0;
      case (paddr)
        A_CTRL: prdata_nxt[CTRL_MCHK] = mchk_r;
        A_STATUS: begin
          prdata_nxt[ST_STATE_LSB +: 3] = st_r;
          prdata_nxt[ST_LAMP_LSB +: N_OFUNC] = lamp_r;
          prdata_nxt[ST_MAPERR] = map_err_r;
          prdata_nxt[ST_PVALID] = pvalid_r;
          prdata_nxt[ST_MCHK] = mchk_r;
          prdata_nxt[ST_SCAN] = scan_r;
          prdata_nxt[ST_PIDX_LSB +: PI_W] = pidx_r;
        end
        A_OUTMAP: prdata_nxt[N_OFUNC*SEL_W-1:0] = omap_r;
        A_INMAP: prdata_nxt[N_IFUNC*SEL_W-1:0] = imap_r;
        A_INT_STAT: prdata_nxt[IRQ_W-1:0] = istat_r;
        A_INT_EN: prdata_nxt[IRQ_W-1:0] = ien_r;
        A_PCODE: prdata_nxt[PROG_W-1:0] = pcode_r;
        A_PTAB_ADDR: prdata_nxt[PI_W-1:0] = ptab_a_r;
        default: ;
      endcase
    end
  end

  // write-only registers read as zero; holes answer with an error
  always_comb begin
    pready = 1'b1;
    pslverr = psel & penable & ~(paddr inside {A_CTRL, A_STATUS, A_OUTMAP, A_INMAP,
      A_INT_STAT, A_INT_CLR, A_INT_EN, A_PCODE, A_PTAB_ADDR, A_PTAB_DATA});
    irq = |(istat_r & ien_r);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_IDLE;
      mchk_r <= 1'b0;
      omap_r <= OUTMAP_RST;
      imap_r <= INMAP_RST;
      istat_r <= '0;
      ien_r <= '0;
      ptab_a_r <= '0;
      prdata <= '0;
      start_q_r <= 1'b0;
      prog_q_r <= 1'b0;
      map_err_r <= 1'b0;
      scan_r <= 1'b0;
      chk_r <= 1'b0;
      sidx_r <= '0;
      cidx_r <= '0;
      pidx_r <= '0;
      pcode_r <= '0;
      pvalid_r <= 1'b0;
      bcnt_r <= '0;
      blink_r <= 1'b0;
      lamp_r <= '0;
      out_lines <= '0;
      soldering_enable <= 1'b0;
    end else begin
      st_r <= st_nxt;
      mchk_r <= mchk_nxt;
      omap_r <= omap_nxt;
      imap_r <= imap_nxt;
      istat_r <= istat_nxt;
      ien_r <= ien_nxt;
      ptab_a_r <= ptab_a_nxt;
      prdata <= prdata_nxt;
      start_q_r <= fin.start;
      prog_q_r <= fin.prog;
      map_err_r <= map_err_nxt;
      scan_r <= scan_nxt;
      chk_r <= chk_nxt;
      sidx_r <= sidx_nxt;
      cidx_r <= cidx_nxt;
      pidx_r <= pidx_nxt;
      pcode_r <= pcode_nxt;
      pvalid_r <= pvalid_nxt;
      bcnt_r <= bcnt_nxt;
      blink_r <= blink_nxt;
      lamp_r <= lamp_nxt;
      out_lines <= out_nxt;
      soldering_enable <= solder_nxt;
    end
  end

  // stored program numbers; software fills them through the data port
  slsio_prog_mem #(
    .DEPTH(PROG_DEPTH),
    .WIDTH(PROG_W)
  ) u_mem (
    .clk(pclk),
    .we(ptab_we),
    .waddr(ptab_a_r),
    .wdata(pwdata[PROG_W-1:0]),
    .raddr(sidx_r),
    .rdata(mem_rd)
  );
endmodule
`default_nettype wire

// ---- shared/slsio_pkg.sv ----
package slsio_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int BLINK_HALF_MS = 250;
  localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;
  // line counts and widths
  localparam int N_OUT = 10;
  localparam int N_IN = 12;
  localparam int SEL_W = 4;
  localparam int N_OFUNC = 4;
  localparam int N_IFUNC = 6;
  localparam int PROG_W = 8;
  localparam int N_PROG = 16;
  // register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_OUTMAP = 8'h08;
  localparam logic [7:0] A_INMAP = 8'h0C;
  localparam logic [7:0] A_INT_STAT = 8'h10;
  localparam logic [7:0] A_INT_CLR = 8'h14;
  localparam logic [7:0] A_INT_EN = 8'h18;
  localparam logic [7:0] A_PCODE = 8'h1C;
  localparam logic [7:0] A_PTAB_ADDR = 8'h20;
  localparam logic [7:0] A_PTAB_DATA = 8'h24;
  // control register bits
  localparam int CTRL_START = 0;
  localparam int CTRL_PAUSE = 1;
  localparam int CTRL_STOP = 2;
  localparam int CTRL_RESUME = 3;
  localparam int CTRL_ECLR = 4;
  localparam int CTRL_MCHK = 8;
  // status register fields
  localparam int ST_STATE_LSB = 0;
  localparam int ST_LAMP_LSB = 4;
  localparam int ST_MAPERR = 8;
  localparam int ST_PVALID = 9;
  localparam int ST_MCHK = 10;
  localparam int ST_SCAN = 11;
  localparam int ST_PIDX_LSB = 16;
  // interrupt bits
  localparam int IRQ_ESTOP = 0;
  localparam int IRQ_FAULT = 1;
  localparam int IRQ_STOP = 2;
  localparam int IRQ_PFOUND = 3;
  localparam int IRQ_PMISS = 4;
  localparam int IRQ_MAPERR = 5;
  localparam int IRQ_W = 6;
  // reset line assignments, one nibble per function
  localparam logic [N_OFUNC*SEL_W-1:0] OUTMAP_RST = 16'h3210;
  localparam logic [N_IFUNC*SEL_W-1:0] INMAP_RST = 24'h543210;

  typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_PAUSE, ST_FPAUSE, ST_ESTOP} slsio_state_t;

  // lamp functions, bit order matches the output map nibbles
  typedef struct packed {
    logic activity;
    logic fault;
    logic idle;
    logic operating;
  } slsio_lamp_t;

  // input functions, bit order matches the input map nibbles
  typedef struct packed {
    logic area2;
    logic area_pause;
    logic area_estop;
    logic prog;
    logic start;
    logic estop;
  } slsio_fin_t;
endpackage

// ---- rtl/slsio_prog_mem.sv ----
`timescale 1ns/100ps
`default_nettype none
module slsio_prog_mem #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  // no reset: contents are undefined until software fills the table
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// ---- sim/slsio_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
module slsio_sva
  import slsio_pkg::*;
#(
  parameter int BLINK_CYC = 4,
  parameter int PROG_DEPTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic [N_OUT-1:0] out_lines,
  input wire logic soldering_enable
);
  int dark_r;
  int dark_nxt;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_rd_access;
    psel && penable && !pwrite;
  endsequence
  sequence s_lamp_run;
    out_lines[0] && !out_lines[1];
  endsequence
  // dark spell of the activity lamp while operating, bounded by the blink half period
  always_comb begin
    dark_nxt = (out_lines[0] && !out_lines[3]) ? dark_r + 1 : 0;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      dark_r <= 0;
    else
      dark_r <= dark_nxt;
  end
  a_act_needs_op: assert property (out_lines[3] |-> out_lines[0])
    else $error("activity lit without operating");
  a_fault_idle_lit: assert property (out_lines[2] |-> out_lines[1])
    else $error("fault lit without idle");
  a_run_no_fault: assert property (s_lamp_run |-> !out_lines[2])
    else $error("fault lit in plain run");
  a_blink_dark: assert property (dark_r <= BLINK_CYC)
    else $error("activity dark too long");
  a_solder_run: assert property ($rose(soldering_enable) |-> ##[0:3] s_lamp_run)
    else $error("solder enable without run lamps");
  a_slverr_phase: assert property (pslverr |-> psel && penable)
    else $error("slave error outside access");
  a_err_read_zero: assert property (s_rd_access ##0 pslverr |-> prdata == 32'h0)
    else $error("refused read gave data");
  a_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved without read setup");
endmodule
bind slsio_top slsio_sva #(.BLINK_CYC(BLINK_CYC), .PROG_DEPTH(PROG_DEPTH)) u_sva (.pclk, .presetn, .psel,
  .penable, .pwrite, .prdata, .pslverr, .out_lines, .soldering_enable);
`default_nettype wire

// ---- sim/slsio_panel.sv ----
`timescale 1ns/100ps
`default_nettype none
module slsio_panel
  import slsio_pkg::*;
(
  input wire logic pclk,
  input wire logic [N_OUT-1:0] out_lines,
  output logic [N_IN-1:0] in_lines
);
  int toggles;
  logic act_q;
  initial begin
    in_lines = '0;
    toggles = 0;
    act_q = 1'h0;
  end
  // lamp flips counted on the falling edge, clear of rising-edge updates
  always @(negedge pclk) begin
    if (out_lines[3] !== act_q)
      toggles++;
    act_q = out_lines[3];
  end
  // contacts hold their level until moved, one move per clock edge
  task automatic set_line(input int n, input logic v);
    @(posedge pclk);
    in_lines[n] <= v;
  endtask
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb
  import slsio_pkg::*;
();
  localparam int BLINK = 4;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  typedef struct {
    logic [31:0] e;
    logic [31:0] m;
    logic s;
  } slsio_note_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic feed_fault, unit_fault, prog_done, soldering_enable, irq;
  logic [7:0] paddr, base, k, code;
  logic [31:0] pwdata, prdata;
  logic [N_IN-1:0] in_lines;
  logic [N_OUT-1:0] out_lines;
  slsio_note_t nq[$];
  slsio_note_t n;
  int fail_count, checks, seed, t0;
  int ln[5] = '{0, 3, 5, 3, 5};

  slsio_top #(.BLINK_CYC(BLINK)) u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .in_lines(in_lines), .prog_code_pins(code), .feed_fault(feed_fault),
    .unit_fault(unit_fault), .prog_done(prog_done), .out_lines(out_lines),
    .soldering_enable(soldering_enable), .irq(irq));
  slsio_panel u_pan (.pclk(pclk), .out_lines(out_lines), .in_lines(in_lines));

  always #20 pclk = ~pclk;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge pclk);
  endtask
  // one transfer, then an idle cycle so no strobe is set twice in a step
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'h1;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1)
      @(posedge pclk);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'h1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    // every word above the last register is a hole and must be refused
    nq.push_back('{e & m, m, a > A_PTAB_DATA});
    apb(a, 1'h0, 32'h0);
  endtask
  task automatic ctl(input logic [31:0] d);
    wr(A_CTRL, d);
    tick(4);
  endtask
  task automatic st(input logic [2:0] s, input logic [2:0] l);
    chk("lamps", 32'(l), 32'(out_lines[2:0]));
    rd(A_STATUS, {25'h0, l, 1'h0, s}, 32'h77);
  endtask
  task automatic blinks();
    t0 = u_pan.toggles;
    tick(40);
    chk("blinks", 32'(40 / BLINK), 32'(u_pan.toggles - t0));
  endtask
  task automatic pulse(input int p);
    u_pan.set_line(p, 1'h1);
    tick(10);
    u_pan.set_line(p, 1'h0);
    tick(30);
  endtask
  task automatic flt(input logic [1:0] v);
    {feed_fault, unit_fault} <= v;
    tick(2);
    {feed_fault, unit_fault} <= 2'h0;
    tick(6);
  endtask
  task automatic summarize();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // read data is judged in arrival order against the notes left by rd
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && nq.size() > 0) begin
      n = nq.pop_front();
      chk("prdata", n.e, prdata & n.m);
      chk("pslverr", 32'(n.s), 32'(pslverr));
    end
  end

  initial begin
    {pclk, presetn, psel, penable, pwrite, feed_fault, unit_fault, prog_done} = 8'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    code = 8'h00;
    fail_count = 0;
    checks = 0;
    seed = 72470;
    tick(10);
    presetn <= 1'h1;
    tick(3);
    st(3'h0, 3'h2);
    rd(A_OUTMAP, 32'h3210, ALL);
    rd(A_INMAP, 32'h543210, ALL);
    rd(A_INT_EN, 32'h0, ALL);
    rd(8'h40, 32'h0, ALL);
    $display("test reset done");
    base = 8'($random(seed));
    k = 8'($random(seed)) & 8'h0F;
    for (int i = 0; i < N_PROG; i++) begin
      wr(A_PTAB_ADDR, 32'(i));
      wr(A_PTAB_DATA, 32'(8'(base + 8'(3 * i))));
    end
    code <= base + 8'h01;
    pulse(2);
    rd(A_INT_STAT, 32'h10, 32'h10);
    code <= base + 8'(3 * k);
    pulse(2);
    rd(A_STATUS, {12'h0, k[3:0], 16'h0200}, 32'h000F0200);
    rd(A_PCODE, 32'(code), ALL);
    $display("test program select done");
    pulse(1);
    st(3'h1, 3'h1);
    chk("solder_en", 32'h1, 32'(soldering_enable));
    blinks();
    flt(2'h2);
    st(3'h3, 3'h7);
    blinks();
    chk("irq", 32'h0, 32'(irq));
    rd(A_INT_STAT, 32'h2, 32'h2);
    ctl(32'h8);
    st(3'h1, 3'h1);
    u_pan.set_line(4, 1'h1);
    tick(10);
    st(3'h2, 3'h3);
    u_pan.set_line(4, 1'h0);
    tick(10);
    ctl(32'h8);
    ctl(32'h2);
    st(3'h2, 3'h3);
    ctl(32'h8);
    pulse(1);
    st(3'h0, 3'h2);
    rd(A_INT_STAT, 32'h4, 32'h4);
    $display("test pause and stop done");
    wr(A_INT_EN, 32'h1);
    // three runs broken by each stop source, then both area inputs seen from idle
    for (int j = 0; j < 5; j++) begin
      if (j < 3)
        ctl(32'h1);
      u_pan.set_line(ln[j], 1'h1);
      tick(10);
      st((j < 4) ? 3'h4 : 3'h0, (j < 4) ? 3'h6 : 3'h2);
      chk("irq", 32'(j < 4), 32'(irq));
      u_pan.set_line(ln[j], 1'h0);
      tick(10);
      wr(A_CTRL, 32'h10);
      wr(A_INT_CLR, 32'h1);
      tick(4);
      st(3'h0, 3'h2);
      chk("irq", 32'h0, 32'(irq));
    end
    wr(A_INT_EN, 32'h0);
    $display("test emergency stops done");
    ctl(32'h100);
    ctl(32'h101);
    st(3'h1, 3'h1);
    chk("solder_en", 32'h0, 32'(soldering_enable));
    flt(2'h1);
    st(3'h3, 3'h7);
    ctl(32'h4);
    st(3'h0, 3'h2);
    ctl(32'h1);
    prog_done <= 1'h1;
    tick(1);
    prog_done <= 1'h0;
    tick(4);
    st(3'h0, 3'h2);
    $display("test motion check done");
    wr(A_OUTMAP, 32'h3290);
    tick(4);
    chk("lines", 32'h200, 32'(out_lines));
    wr(A_OUTMAP, 32'h3211);
    tick(4);
    rd(A_STATUS, 32'h100, 32'h100);
    rd(A_INT_STAT, 32'h20, 32'h20);
    wr(A_OUTMAP, 32'h3210);
    wr(A_INMAP, 32'h543270);
    pulse(7);
    st(3'h1, 3'h1);
    pulse(7);
    st(3'h0, 3'h2);
    $display("test line mapping done");
    summarize();
  end

  // cuts a hang short well after the whole sequence should be over
  initial begin
    tick(20000);
    fail_count++;
    summarize();
  end
endmodule
`default_nettype wire
